// file: fifo_ports_consts.vh
`ifndef FIFO_PORTS_CONSTS_VH
`define FIFO_PORTS_CONSTS_VH

// ****************************************
// storage geometry
// ****************************************
`define FIFO_DEPTH      7'd64
`define FIFO_DW         36
`define PTR_W           7
`define IDX_W           6

// ****************************************
// flag offset values picked at reset release
// ****************************************
`define OFFSET_HH       5'd16
`define OFFSET_HL       5'd12
`define OFFSET_LH       5'd8
`define OFFSET_LL       5'd4

// ****************************************
// port b size codes {size_sel_high, size_sel_low}
// ****************************************
`define SIZE_LONG       2'b00
`define SIZE_WORD       2'b01
`define SIZE_BYTE       2'b10
`define SIZE_MAIL       2'b11
`define WORD_BITS       18
`define BYTE_BITS       9
`define WORD_LEFT       2'd1
`define BYTE_LEFT       2'd3

// ****************************************
// register map and bus answers
// ****************************************
`define ADDR_W          8
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_LEVEL       8'h08
`define CTRL_FLUSH_BIT  0
`define RESP_OKAY       2'b00
`define RESP_DECERR     2'b11

`endif

// file: fifo_flags_ports.v
`default_nettype none
`include "fifo_ports_consts.vh"

module fifo_flags_ports (
  // clock and bus reset
  input  wire                    aclk,
  input  wire                    aresetn,
  // axi4-lite write address and data
  input  wire [`ADDR_W-1:0]      s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  // axi4-lite read
  input  wire [`ADDR_W-1:0]      s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  // device reset and offset straps
  input  wire                    reset_n,
  input  wire                    offset_pick0,
  input  wire                    offset_pick1,
  // port a pins
  input  wire                    clock_a,
  input  wire                    port_a_select_n,
  input  wire                    port_a_write_not_read,
  input  wire                    port_a_strobe,
  input  wire                    port_a_mailbox_select,
  input  wire [`FIFO_DW-1:0]     port_a_data_in,
  output reg  [`FIFO_DW-1:0]     port_a_data_out,
  output wire                    port_a_data_oe,
  // port b pins
  input  wire                    clock_b,
  input  wire                    port_b_select_n,
  input  wire                    port_b_write_not_read,
  input  wire                    port_b_strobe,
  input  wire                    port_b_size_sel_low,
  input  wire                    port_b_size_sel_high,
  input  wire [`FIFO_DW-1:0]     port_b_data_in,
  output reg  [`FIFO_DW-1:0]     port_b_data_out,
  output wire                    port_b_data_oe,
  // flags
  output wire                    full_n,
  output wire                    almost_full_n,
  output wire                    empty_n,
  output wire                    almost_empty_n,
  output reg                     mail_to_b_flag,
  output reg                     mail_to_a_flag
);

  // ****************************************
  // helpers
  // ****************************************
  function [`PTR_W-1:0] bin2gray;
    input [`PTR_W-1:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [`PTR_W-1:0] gray2bin;
    input [`PTR_W-1:0] g;
    integer i;
    begin
      gray2bin[`PTR_W-1] = g[`PTR_W-1];
      for (i = `PTR_W - 2; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam IN_W = 86;
  wire [IN_W-1:0] pin_raw;
  reg  [IN_W-1:0] pin_s1;
  reg  [IN_W-1:0] pin_s2;

  assign pin_raw = {reset_n, offset_pick1, offset_pick0,
                    clock_a, port_a_select_n, port_a_write_not_read,
                    port_a_strobe, port_a_mailbox_select, port_a_data_in,
                    clock_b, port_b_select_n, port_b_write_not_read,
                    port_b_strobe, port_b_size_sel_high, port_b_size_sel_low,
                    port_b_data_in};

  // two stages before any logic looks at a pin
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= {IN_W{1'b0}};
      pin_s2 <= {IN_W{1'b0}};
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  wire                rst_pin_s = pin_s2[85];
  wire [1:0]          pick_s    = pin_s2[84:83];
  wire                clock_a_s    = pin_s2[82];
  wire                a_sel_n   = pin_s2[81];
  wire                a_wnr     = pin_s2[80];
  wire                a_strobe  = pin_s2[79];
  wire                a_mbox    = pin_s2[78];
  wire [`FIFO_DW-1:0] a_din     = pin_s2[77:42];
  wire                clock_b_s    = pin_s2[41];
  wire                b_sel_n   = pin_s2[40];
  wire                b_wnr     = pin_s2[39];
  wire                b_strobe  = pin_s2[38];
  wire [1:0]          b_size    = pin_s2[37:36];
  wire [`FIFO_DW-1:0] b_din     = pin_s2[35:0];

  // ****************************************
  // port clock edges and device reset
  // ****************************************
  reg        clock_a_d;
  reg        clock_b_d;
  reg        rst_pin_d;
  reg        ctrl_flush;
  reg  [4:0] flag_offset;
  wire       a_tick  = clock_a_s & ~clock_a_d;
  wire       b_tick  = clock_b_s & ~clock_b_d;
  wire       dev_rst = ~aresetn | ~rst_pin_s | ctrl_flush;

  // edge detectors, offset latched on reset_n release
  always @(posedge aclk) begin
    if (!aresetn) begin
      clock_a_d      <= 1'b0;
      clock_b_d      <= 1'b0;
      rst_pin_d   <= 1'b0;
      flag_offset <= `OFFSET_LL;
    end else begin
      clock_a_d    <= clock_a_s;
      clock_b_d    <= clock_b_s;
      rst_pin_d <= rst_pin_s;
      if (rst_pin_s && !rst_pin_d) begin
        case (pick_s)
          2'b11:   flag_offset <= `OFFSET_HH;
          2'b10:   flag_offset <= `OFFSET_HL;
          2'b01:   flag_offset <= `OFFSET_LH;
          default: flag_offset <= `OFFSET_LL;
        endcase
      end
    end
  end

  // ****************************************
  // storage and pointers
  // ****************************************
  reg [`FIFO_DW-1:0] mem [0:63];
  reg [`PTR_W-1:0]   wbin;
  reg [`PTR_W-1:0]   wgray;
  reg [`PTR_W-1:0]   rbin;
  reg [`PTR_W-1:0]   rgray;
  reg [`PTR_W-1:0]   rsync1;
  reg [`PTR_W-1:0]   rsync2;
  reg [`PTR_W-1:0]   wsync1;
  reg [`PTR_W-1:0]   wsync2;
  reg [1:0]          a_up;
  reg [1:0]          b_up;
  reg [`PTR_W-1:0]   count_a;
  reg [`PTR_W-1:0]   count_b;

  // ****************************************
  // port a decode
  // ****************************************
  wire a_xfer  = a_tick & ~a_sel_n & a_strobe;
  wire fifo_wr = a_xfer & a_wnr & ~a_mbox & full_n;
  wire mb1_wr  = a_xfer & a_wnr & a_mbox & mail_to_b_flag;
  wire mb2_rd  = a_xfer & ~a_wnr & a_mbox;

  assign port_a_data_oe = ~a_sel_n & ~a_wnr;

  // write side: storage, write pointer, read pointer sync
  always @(posedge aclk) begin
    if (fifo_wr) begin
      mem[wbin[`IDX_W-1:0]] <= a_din;
    end
  end

  always @(posedge aclk) begin
    if (dev_rst) begin
      wbin   <= {`PTR_W{1'b0}};
      wgray  <= {`PTR_W{1'b0}};
      rsync1 <= {`PTR_W{1'b0}};
      rsync2 <= {`PTR_W{1'b0}};
      a_up   <= 2'b00;
    end else begin
      if (fifo_wr) begin
        wbin  <= wbin + 7'd1;
        wgray <= bin2gray(wbin + 7'd1);
      end
      if (a_tick) begin
        rsync1 <= rgray;
        rsync2 <= rsync1;
        a_up   <= {a_up[0], 1'b1};
      end
    end
  end

  // fill level as seen by the write side
  always @* begin
    count_a = wbin - gray2bin(rsync2);
  end

  assign full_n        = a_up[1] & (count_a != `FIFO_DEPTH);
  assign almost_full_n = ~a_up[1] |
                         (count_a < (`FIFO_DEPTH - {2'b00, flag_offset}));

  // ****************************************
  // port b decode
  // ****************************************
  reg  [1:0]          left;
  reg  [1:0]          cur_size;
  reg  [`FIFO_DW-1:0] aux;
  reg  [`FIFO_DW-1:0] out_reg;
  wire                b_mail   = (b_size == `SIZE_MAIL);
  wire                b_xfer   = b_tick & ~b_sel_n & b_strobe;
  wire                ram_empty = (wsync2 == rgray);
  wire                need_pop = (left == 2'd0) | (b_size != cur_size);
  wire                rd_try   = b_xfer & ~b_wnr & ~b_mail & empty_n;
  wire                pop      = rd_try & need_pop & ~ram_empty;
  wire                shift    = rd_try & ~need_pop;
  wire                mb1_rd   = b_xfer & ~b_wnr & b_mail;
  wire                mb2_wr   = b_xfer & b_wnr & b_mail & mail_to_a_flag;
  wire [`FIFO_DW-1:0] ram_word = mem[rbin[`IDX_W-1:0]];

  assign port_b_data_oe = ~b_sel_n & ~b_wnr;

  // read side: pointer, output and auxiliary registers, write pointer sync
  always @(posedge aclk) begin
    if (dev_rst) begin
      rbin     <= {`PTR_W{1'b0}};
      rgray    <= {`PTR_W{1'b0}};
      wsync1   <= {`PTR_W{1'b0}};
      wsync2   <= {`PTR_W{1'b0}};
      b_up     <= 2'b00;
      left     <= 2'd0;
      cur_size <= `SIZE_LONG;
      aux      <= {`FIFO_DW{1'b0}};
      out_reg  <= {`FIFO_DW{1'b0}};
    end else begin
      if (b_tick) begin
        wsync1 <= wgray;
        wsync2 <= wsync1;
        b_up   <= {b_up[0], 1'b1};
      end
      if (pop) begin
        rbin     <= rbin + 7'd1;
        rgray    <= bin2gray(rbin + 7'd1);
        cur_size <= b_size;
        case (b_size)
          `SIZE_WORD: begin
            out_reg[`WORD_BITS-1:0] <= ram_word[`WORD_BITS-1:0];
            aux  <= ram_word >> `WORD_BITS;
            left <= `WORD_LEFT;
          end
          `SIZE_BYTE: begin
            out_reg[`BYTE_BITS-1:0] <= ram_word[`BYTE_BITS-1:0];
            aux  <= ram_word >> `BYTE_BITS;
            left <= `BYTE_LEFT;
          end
          default: begin
            out_reg <= ram_word;
            left    <= 2'd0;
          end
        endcase
      end else if (shift) begin
        left <= left - 2'd1;
        if (cur_size == `SIZE_WORD) begin
          out_reg[`WORD_BITS-1:0] <= aux[`WORD_BITS-1:0];
          aux <= aux >> `WORD_BITS;
        end else begin
          out_reg[`BYTE_BITS-1:0] <= aux[`BYTE_BITS-1:0];
          aux <= aux >> `BYTE_BITS;
        end
      end
    end
  end

  // fill level as seen by the read side
  always @* begin
    count_b = gray2bin(wsync2) - rbin;
  end

  // low while nothing left in storage nor in the auxiliary register
  assign empty_n = b_up[1] & (~ram_empty | (left != 2'd0));
  assign almost_empty_n = b_up[1] &
                          (count_b > {2'b00, flag_offset});

  // ****************************************
  // mailboxes
  // ****************************************
  reg [`FIFO_DW-1:0] mail_to_b_data;
  reg [`FIFO_DW-1:0] mail_to_a_data;

  // a write that meets a read in the same cycle wins
  always @(posedge aclk) begin
    if (dev_rst) begin
      mail_to_b_flag <= 1'b1;
      mail_to_a_flag <= 1'b1;
      mail_to_b_data <= {`FIFO_DW{1'b0}};
      mail_to_a_data <= {`FIFO_DW{1'b0}};
    end else begin
      if (mb1_wr) begin
        mail_to_b_flag <= 1'b0;
        mail_to_b_data <= a_din;
      end else if (mb1_rd) begin
        mail_to_b_flag <= 1'b1;
      end
      if (mb2_wr) begin
        mail_to_a_flag <= 1'b0;
        mail_to_a_data <= b_din;
      end else if (mb2_rd) begin
        mail_to_a_flag <= 1'b1;
      end
    end
  end

  // data pins from flip-flops, one aclk behind the selects
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_a_data_out <= {`FIFO_DW{1'b0}};
      port_b_data_out <= {`FIFO_DW{1'b0}};
    end else begin
      port_a_data_out <= mail_to_a_data;
      port_b_data_out <= b_mail ? mail_to_b_data : out_reg;
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  reg               aw_held;
  reg               w_held;
  reg [`ADDR_W-1:0] aw_addr;
  reg [31:0]        w_data;
  reg [3:0]         w_strb;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // write path: address and data in either order, then response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= {`ADDR_W{1'b0}};
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      ctrl_flush   <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `REG_CTRL) begin
          s_axi_bresp <= `RESP_OKAY;
          if (w_strb[0]) begin
            ctrl_flush <= w_data[`CTRL_FLUSH_BIT];
          end
        end else if (aw_addr == `REG_STATUS || aw_addr == `REG_LEVEL) begin
          s_axi_bresp <= `RESP_OKAY;              // read-only, write dropped
        end else begin
          s_axi_bresp <= `RESP_DECERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read path: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      case (s_axi_araddr)
        `REG_CTRL:   s_axi_rdata <= {31'h0000_0000, ctrl_flush};
        `REG_STATUS: s_axi_rdata <= {26'h000_0000, mail_to_a_flag,
                                     mail_to_b_flag, almost_full_n, full_n,
                                     almost_empty_n, empty_n};
        `REG_LEVEL:  s_axi_rdata <= {11'h000, flag_offset, 1'b0, count_a,
                                     1'b0, count_b};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: fifo_flags_ports_assertions.sv
`default_nettype none
// ****************************************
// port, flag and bus checks
// ****************************************
module fifo_flags_ports_checker (
  // clock and resets
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        reset_n,
  input wire logic        clock_b,
  // port a pins
  input wire logic        port_a_select_n,
  input wire logic        port_a_write_not_read,
  input wire logic        port_a_data_oe,
  // port b pins
  input wire logic        port_b_select_n,
  input wire logic        port_b_write_not_read,
  input wire logic        port_b_strobe,
  input wire logic        port_b_size_sel_low,
  input wire logic        port_b_size_sel_high,
  input wire logic        port_b_data_oe,
  // flags
  input wire logic        full_n,
  input wire logic        almost_full_n,
  input wire logic        empty_n,
  input wire logic        almost_empty_n,
  input wire logic        mail_to_b_flag,
  input wire logic        mail_to_a_flag,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // output enables follow pins after two sync stages
  chk_oe_a_decode: assert property (
    $past(aresetn, 3) |-> port_a_data_oe ==
    (!$past(port_a_select_n, 2) && !$past(port_a_write_not_read, 2)))
    else $error("port a enable wrong");
  chk_oe_b_decode: assert property (
    $past(aresetn, 3) |-> port_b_data_oe ==
    (!$past(port_b_select_n, 2) && !$past(port_b_write_not_read, 2)))
    else $error("port b enable wrong");
  // device reset forces flag levels
  chk_reset_flags: assert property (
    !reset_n [*4] |-> !full_n && !empty_n && !almost_empty_n &&
    almost_full_n && mail_to_b_flag && mail_to_a_flag)
    else $error("reset flag levels wrong");
  chk_empty_almost: assert property (!empty_n |-> !almost_empty_n)
    else $error("almost empty high while empty");
  // mailbox read on port b raises its flag
  chk_mail_b_read: assert property (
    !port_b_select_n && !port_b_write_not_read
    && port_b_strobe && port_b_size_sel_low && port_b_size_sel_high &&
    $rose(clock_b) |-> ##[1:6] mail_to_b_flag)
    else $error("mail flag not raised");
  // bus answers
  chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken during response");
  chk_write_resp: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read response late");
  chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
endmodule
`default_nettype wire

// file: port_a_host.sv
`default_nettype none
// ****************************************
// port a host model
// ****************************************
module port_a_host (
  // bus clock
  input wire logic        aclk,
  // port a pins
  output logic            clock_a,
  output logic            port_a_select_n,
  output logic            port_a_write_not_read,
  output logic            port_a_strobe,
  output logic            port_a_mailbox_select,
  output logic [35:0]     port_a_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle pins, free-running port clock
  initial begin
    clock_a = 1'b0;
    port_a_select_n = 1'b1;
    port_a_write_not_read = 1'b0;
    port_a_strobe = 1'b0;
    port_a_mailbox_select = 1'b0;
    port_a_data_in = '0;
  end
  always #62.5 clock_a = ~clock_a;
  // one transfer, pins stable across the clock_a rise
  task automatic op(input logic wr, input logic mb, input logic [35:0] d);
    @(negedge clock_a);
    @(posedge aclk);
    port_a_select_n <= 1'b0;
    port_a_write_not_read <= wr;
    port_a_strobe <= 1'b1;
    port_a_mailbox_select <= mb;
    port_a_data_in <= wr ? d : ~port_a_data_in; // released bus flips
    @(posedge clock_a);
    @(negedge clock_a);
    @(posedge aclk);
    port_a_strobe <= 1'b0;
    port_a_select_n <= ~port_a_select_n;
    repeat (8) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`default_nettype none
`include "fifo_ports_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, reset_n, offset_pick0, offset_pick1;
  logic        clock_a, clock_b, port_a_data_oe, port_b_data_oe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        port_a_select_n, port_a_write_not_read, port_a_strobe;
  logic        port_a_mailbox_select, port_b_select_n;
  logic        port_b_write_not_read, port_b_strobe;
  logic        port_b_size_sel_low, port_b_size_sel_high;
  logic [35:0] port_a_data_in, port_a_data_out, d;
  logic [35:0] port_b_data_in, port_b_data_out;
  logic        full_n, almost_full_n, empty_n, almost_empty_n;
  logic        mail_to_b_flag, mail_to_a_flag;
  logic [35:0] q [64];
  int          miscompares, check_count;
  fifo_flags_ports dut (.*);
  port_a_host host (.*);
  // clocks: bus 100 MHz, port b 125 ns at its own phase
  always #5 aclk = ~aclk;
  initial begin
    clock_b = 1'b0;
    #31;
    forever #62.5 clock_b = ~clock_b;
  end
  function automatic logic [4:0] exp_offset(input logic [1:0] k);
    return 5'd4 + {1'b0, k, 2'b00};
  endfunction
  task automatic chk(input logic [35:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic settle();
    repeat (40) @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) aw_done = 1'b1;
      if (s_axi_wready === 1'b1) w_done = 1'b1;
      if (aw_done) s_axi_awvalid <= 1'b0;
      if (w_done) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // one port b transfer on the next clock_b rise
  task automatic b_op(input logic wr, input logic [1:0] sz,
                      input logic [35:0] v);
    @(negedge clock_b);
    @(posedge aclk);
    {port_b_select_n, port_b_write_not_read} <= {1'b0, wr};
    port_b_strobe <= 1'b1;
    {port_b_size_sel_high, port_b_size_sel_low} <= sz;
    port_b_data_in <= wr ? v : ~port_b_data_in;
    @(posedge clock_b);
    @(negedge clock_b);
    @(posedge aclk);
    port_b_strobe <= 1'b0;
    port_b_select_n <= 1'($urandom);
    port_b_write_not_read <= 1'($urandom);
    repeat (8) @(posedge aclk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog
  initial begin
    #500000;
    miscompares++;
    stop_test();
  end
  // main sequence
  initial begin
    void'($urandom(8315));
    {aclk, aresetn, reset_n, offset_pick0, offset_pick1} = 5'b00000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {port_b_select_n, port_b_write_not_read, port_b_strobe} = 3'b100;
    {port_b_size_sel_high, port_b_size_sel_low, port_b_data_in} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 3; k >= 0; k--) begin
      @(posedge aclk);
      {offset_pick1, offset_pick0} <= 2'(k);
      reset_n <= 1'b0;
      repeat (80) @(posedge aclk);
      reset_n <= 1'b1;
      repeat (60) @(posedge aclk);
      axi_rd(`REG_LEVEL);
      chk(rd[20:16], exp_offset(2'(k)), "offset");
    end
    axi_rd(`REG_STATUS);
    chk(rd[5:0], 6'b111100, "status after reset");
    axi_rd(8'h40);
    chk(rs, `RESP_DECERR, "unmapped read");
    axi_wr(8'h40, $urandom);
    chk(rs, `RESP_DECERR, "unmapped write");
    $display("test reset done");
    for (int i = 0; i < 64; i++) begin
      q[i] = {4'($urandom), $urandom};
      host.op(1'b1, 1'b0, q[i]);
      if (i inside {0, 3, 4, 58, 59}) begin
        settle();
        chk(empty_n, 1'b1, "empty_n after write");
        chk(almost_empty_n, i >= 4, "almost empty");
        chk(almost_full_n, i < 59, "almost full");
      end
    end
    settle();
    chk(full_n, 1'b0, "full");
    host.op(1'b1, 1'b0, ~q[0]);
    $display("test fill done");
    for (int i = 0; i < 64; i++) begin
      b_op(1'b0, `SIZE_LONG, '0);
      chk(port_b_data_out, q[i], "fifo order");
      if (i == 0) begin
        settle();
        chk(full_n, 1'b1, "full_n after read");
      end
    end
    settle();
    chk(empty_n, 1'b0, "empty after drain");
    b_op(1'b0, `SIZE_LONG, '0);
    chk(port_b_data_out, q[63], "read while empty");
    $display("test drain done");
    d = {4'($urandom), $urandom};
    host.op(1'b1, 1'b0, d);
    settle();
    for (int p = 0; p < 4; p++) begin
      b_op(1'b0, `SIZE_BYTE, '0);
      chk(port_b_data_out[8:0], d[9*p +: 9], "byte part");
    end
    settle();
    chk(empty_n, 1'b0, "empty after last byte");
    d = {4'($urandom), $urandom};
    host.op(1'b1, 1'b0, d);
    settle();
    for (int p = 0; p < 2; p++) begin
      b_op(1'b0, `SIZE_WORD, '0);
      chk(port_b_data_out[17:0], d[18*p +: 18], "word part");
    end
    settle();
    chk(empty_n, 1'b0, "empty after last word");
    $display("test bytes done");
    d = {4'($urandom), $urandom};
    host.op(1'b1, 1'b1, d);
    settle();
    chk(mail_to_b_flag, 1'b0, "mail to b waiting");
    host.op(1'b1, 1'b1, ~d);
    b_op(1'b0, `SIZE_MAIL, '0);
    chk(port_b_data_out, d, "mail to b data");
    settle();
    chk(mail_to_b_flag, 1'b1, "mail to b read");
    d = {4'($urandom), $urandom};
    b_op(1'b1, `SIZE_MAIL, d);
    settle();
    chk(mail_to_a_flag, 1'b0, "mail to a waiting");
    host.op(1'b0, 1'b1, '0);
    chk(port_a_data_out, d, "mail to a data");
    settle();
    chk(mail_to_a_flag, 1'b1, "mail to a read");
    $display("test mail done");
    host.op(1'b1, 1'b0, d);
    axi_wr(`REG_CTRL, 32'h0000_0001);
    settle();
    axi_rd(`REG_CTRL);
    chk(rd[0], 1'b1, "flush held");
    axi_rd(`REG_STATUS);
    chk(rd[5:0], 6'b111000, "status in flush");
    axi_wr(`REG_CTRL, 32'h0000_0000);
    chk(rs, `RESP_OKAY, "control write");
    settle();
    axi_rd(`REG_STATUS);
    chk(rd[5:0], 6'b111100, "status after flush");
    $display("test flush done");
    stop_test();
  end
endmodule
bind fifo_flags_ports fifo_flags_ports_checker chk_i (.*);
`default_nettype wire
